// ===== core/can_host_pkg.sv
// constants, types and register map of the host pin interface
package can_host_pkg;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] CPU_IF_CTRL_OFFSET = 8'h02;
   localparam logic [7:0] CPU_IF_CTRL_RESET = 8'h00;
   localparam int INT_PIN_SELECT_BIT = 5;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ------------------------------------------------------------
   // straps and timing
   // ------------------------------------------------------------
   localparam logic [1:0] BUS_TYPE_NONMUX = 2'h3;
   localparam logic [1:0] STRAP_CYCLES = 2'h3;
   localparam int CLOCK_PERIOD_PS = 4000;
   localparam int ACK_PULLUP_NS = 10;
   localparam int ACK_PULLUP_CYCLES = (ACK_PULLUP_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

   // ------------------------------------------------------------
   // serial frame: write flag, 7-bit address, 8-bit data
   // ------------------------------------------------------------
   localparam int SER_FRAME_BITS = 16;
   localparam logic [4:0] SER_ADDR_LAST = 5'h07;
   localparam logic [4:0] SER_FRAME_LAST = 5'h0f;
   localparam logic [7:0] SER_RELEASED = 8'hff;

   // ------------------------------------------------------------
   // carriers and states
   // ------------------------------------------------------------
   typedef struct packed {
      logic cs_n;
      logic rw_n;
      logic addr_ok_in;
      logic [7:0] addr;
      logic [7:0] data;
      logic sclk;
      logic ser_cs_n;
      logic mosi;
      logic sample_phase;
      logic serial_clk_idle_level;
      logic [1:0] bus_type;
      logic serial_mode;
   } pin_in_t;

   typedef struct packed {
      logic write_en;
      logic [7:0] addr;
      logic [7:0] data;
   } host_access_t;

   typedef enum logic [1:0] {
      PAR_IDLE,
      PAR_ACCESS,
      PAR_ACK
   } par_state_t;

endpackage : can_host_pkg

// ===== core/sync_2ff.sv
// two flip-flop synchroniser for a vector of pin levels
module sync_2ff #(
   parameter int WIDTH = 1
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   // first stage feeds only the second stage
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;

endmodule : sync_2ff

// ===== core/can_host_pins.sv
// host pin interface: non-multiplexed bus handshake, serial port, interrupt pin steering
//
// Overview of operation
// - read data valid marked by acknowledge low
// - write data accepted marked by acknowledge low
// - serial clock idles at selected level
// - interrupt steered to one of two pins
// - interrupt pin only ever pulled low
// - serial read data out, open drain
// - sample phase picks serial sampling edge
module can_host_pins (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_rw_n,
   input wire logic i_addr_ok_in,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic i_sclk,
   input wire logic i_ser_cs_n,
   input wire logic i_mosi,
   input wire logic i_sample_phase,
   input wire logic i_serial_clk_idle_level,
   input wire logic i_bus_type_hi,
   input wire logic i_bus_type_lo,
   input wire logic i_serial_mode,
   input wire logic i_irq_req,
   input wire logic i_port2_bit6_out,
   input wire logic i_port2_bit6_oe,
   output logic [7:0] o_data_out,
   output logic o_data_oe,
   output logic o_transfer_ack_out,
   output logic o_transfer_ack_oe,
   output logic o_irq_primary_oe,
   output logic o_half_supply_ref_en,
   output logic o_alt_pin_out,
   output logic o_alt_pin_oe,
   output logic o_miso_oe,
   output logic [7:0] o_cpu_if_ctrl
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   can_host_pkg::pin_in_t pin_raw, pin;
   assign pin_raw = '{cs_n: i_cs_n, rw_n: i_rw_n, addr_ok_in: i_addr_ok_in, addr: i_addr, data: i_data,
                      sclk: i_sclk, ser_cs_n: i_ser_cs_n, mosi: i_mosi, sample_phase: i_sample_phase,
                      serial_clk_idle_level: i_serial_clk_idle_level,
                      bus_type: {i_bus_type_hi, i_bus_type_lo}, serial_mode: i_serial_mode};
   sync_2ff #(
      .WIDTH($bits(can_host_pkg::pin_in_t))
   ) u_pin_sync (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_async(pin_raw),
      .o_sync(pin)
   );
   // ------------------------------------------------------------
   // strap capture after reset release
   // ------------------------------------------------------------
   // the synchronisers hold reset zeros for two cycles, so straps are taken only once they have filled
   logic [1:0] strap_cnt_reg, strap_cnt_next;
   logic par_mode_reg, par_mode_next, ser_mode_reg, ser_mode_next, straps_done;

   always_comb begin
      strap_cnt_next = strap_cnt_reg;
      par_mode_next = par_mode_reg;
      ser_mode_next = ser_mode_reg;
      if (strap_cnt_reg != can_host_pkg::STRAP_CYCLES) begin
         strap_cnt_next = strap_cnt_reg + 2'h1;
         par_mode_next = (pin.bus_type == can_host_pkg::BUS_TYPE_NONMUX);
         ser_mode_next = pin.serial_mode;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         strap_cnt_reg <= 2'h0;
         par_mode_reg <= 1'b0;
         ser_mode_reg <= 1'b0;
      end else begin
         strap_cnt_reg <= strap_cnt_next;
         par_mode_reg <= par_mode_next;
         ser_mode_reg <= ser_mode_next;
      end
   end

   assign straps_done = (strap_cnt_reg == can_host_pkg::STRAP_CYCLES);
   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [7:0] ctrl_reg, ctrl_next;
   can_host_pkg::host_access_t par_acc, ser_acc;

   function automatic logic [7:0] read_data(input logic [7:0] addr, input logic [7:0] ctrl);
      read_data = (addr == can_host_pkg::CPU_IF_CTRL_OFFSET) ? ctrl : can_host_pkg::READ_UNMAPPED;
   endfunction : read_data

   always_comb begin
      ctrl_next = ctrl_reg;
      if (par_acc.write_en && par_acc.addr == can_host_pkg::CPU_IF_CTRL_OFFSET) begin
         ctrl_next = par_acc.data;
      end else if (ser_acc.write_en && ser_acc.addr == can_host_pkg::CPU_IF_CTRL_OFFSET) begin
         ctrl_next = ser_acc.data;
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ctrl_reg <= can_host_pkg::CPU_IF_CTRL_RESET;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   // ------------------------------------------------------------
   // non-multiplexed parallel bus
   // ------------------------------------------------------------
   can_host_pkg::par_state_t par_state_reg, par_state_next;
   logic [7:0] data_out_reg, data_out_next;
   logic data_oe_reg, data_oe_next, ack_out_reg, ack_out_next, ack_oe_reg, ack_oe_next, par_sel;
   logic [1:0] pullup_cnt_reg, pullup_cnt_next;
   assign par_sel = straps_done && par_mode_reg && !pin.cs_n && pin.addr_ok_in;
   always_comb begin
      par_state_next = par_state_reg;
      data_out_next = data_out_reg;
      data_oe_next = data_oe_reg;
      ack_out_next = ack_out_reg;
      ack_oe_next = ack_oe_reg;
      pullup_cnt_next = pullup_cnt_reg;
      par_acc = '{write_en: 1'b0, addr: pin.addr, data: pin.data};
      // brief active pull-up after release, then the pin is left to the external pull-up
      if (pullup_cnt_reg != 2'h0) begin
         pullup_cnt_next = pullup_cnt_reg - 2'h1;
         if (pullup_cnt_reg == 2'h1) begin
            ack_oe_next = 1'b0;
         end
      end
      unique case (par_state_reg)
         can_host_pkg::PAR_IDLE: begin
            // one settle cycle lets address and data bits synchronised apart line up
            if (par_sel) begin
               par_state_next = can_host_pkg::PAR_ACCESS;
            end
         end
         can_host_pkg::PAR_ACCESS: begin
            if (!par_sel) begin
               par_state_next = can_host_pkg::PAR_IDLE;
            end else begin
               if (pin.rw_n) begin
                  data_out_next = read_data(pin.addr, ctrl_reg);
                  data_oe_next = 1'b1;
               end else begin
                  par_acc.write_en = 1'b1;
               end
               ack_out_next = 1'b0;
               ack_oe_next = 1'b1;
               pullup_cnt_next = 2'h0;
               par_state_next = can_host_pkg::PAR_ACK;
            end
         end
         can_host_pkg::PAR_ACK: begin
            if (!par_sel) begin
               data_oe_next = 1'b0;
               ack_out_next = 1'b1;
               pullup_cnt_next = 2'(can_host_pkg::ACK_PULLUP_CYCLES);
               par_state_next = can_host_pkg::PAR_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         par_state_reg <= can_host_pkg::PAR_IDLE;
         data_out_reg <= 8'h00;
         data_oe_reg <= 1'b0;
         ack_out_reg <= 1'b1;
         ack_oe_reg <= 1'b0;
         pullup_cnt_reg <= 2'h0;
      end else begin
         par_state_reg <= par_state_next;
         data_out_reg <= data_out_next;
         data_oe_reg <= data_oe_next;
         ack_out_reg <= ack_out_next;
         ack_oe_reg <= ack_oe_next;
         pullup_cnt_reg <= pullup_cnt_next;
      end
   end

   // ------------------------------------------------------------
   // serial port
   // ------------------------------------------------------------
   localparam int SER_W = can_host_pkg::SER_FRAME_BITS;
   logic [4:0] bit_cnt_reg, bit_cnt_next;
   logic [SER_W-1:0] in_sr_reg, in_sr_next;
   logic [7:0] out_sr_reg, out_sr_next;
   logic sclk_prev_reg, sclk_prev_next, miso_oe_reg, miso_oe_next;
   logic ser_active, sample_edge, shift_edge, leading_is_shift;
   logic [SER_W-1:0] frame;
   assign ser_active = straps_done && ser_mode_reg && !pin.ser_cs_n;
   assign sample_edge = pin.sample_phase ? (sclk_prev_reg && !pin.sclk) : (!sclk_prev_reg && pin.sclk);
   assign shift_edge = pin.sample_phase ? (!sclk_prev_reg && pin.sclk) : (sclk_prev_reg && !pin.sclk);
   // the edge leaving the idle level is the shift edge when idle level and phase differ
   assign leading_is_shift = (pin.serial_clk_idle_level != pin.sample_phase);
   assign frame = {in_sr_reg[SER_W-2:0], pin.mosi};
   always_comb begin
      sclk_prev_next = pin.sclk;
      bit_cnt_next = bit_cnt_reg;
      in_sr_next = in_sr_reg;
      out_sr_next = out_sr_reg;
      miso_oe_next = miso_oe_reg;
      ser_acc = '{write_en: 1'b0, addr: {1'b0, frame[14:8]}, data: frame[7:0]};
      if (!ser_active) begin
         bit_cnt_next = 5'h00;
         in_sr_next = '0;
         out_sr_next = can_host_pkg::SER_RELEASED;
         miso_oe_next = 1'b0;
      end else if (sample_edge) begin
         in_sr_next = frame;
         bit_cnt_next = bit_cnt_reg + 5'h01;
         if (bit_cnt_reg == can_host_pkg::SER_ADDR_LAST) begin
            out_sr_next = read_data({1'b0, frame[6:0]}, ctrl_reg);
         end else if (bit_cnt_reg == can_host_pkg::SER_FRAME_LAST) begin
            ser_acc.write_en = frame[15];
            bit_cnt_next = 5'h00;
         end
      end else if (shift_edge && !(bit_cnt_reg == 5'h00 && leading_is_shift)) begin
         // only zeros are driven; ones are left to the bus pull-up
         miso_oe_next = !out_sr_reg[7];
         out_sr_next = {out_sr_reg[6:0], 1'b1};
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         sclk_prev_reg <= 1'b0;
         bit_cnt_reg <= 5'h00;
         in_sr_reg <= '0;
         out_sr_reg <= can_host_pkg::SER_RELEASED;
         miso_oe_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_prev_next;
         bit_cnt_reg <= bit_cnt_next;
         in_sr_reg <= in_sr_next;
         out_sr_reg <= out_sr_next;
         miso_oe_reg <= miso_oe_next;
      end
   end

   // ------------------------------------------------------------
   // interrupt pin steering
   // ------------------------------------------------------------
   logic irq_pri_oe_reg, irq_pri_oe_next, half_ref_reg, half_ref_next;
   logic alt_out_reg, alt_out_next, alt_oe_reg, alt_oe_next, int_alt;
   assign int_alt = ctrl_reg[can_host_pkg::INT_PIN_SELECT_BIT];
   always_comb begin
      irq_pri_oe_next = !int_alt && i_irq_req;
      half_ref_next = int_alt;
      alt_out_next = int_alt ? 1'b0 : i_port2_bit6_out;
      alt_oe_next = int_alt ? i_irq_req : i_port2_bit6_oe;
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         irq_pri_oe_reg <= 1'b0;
         half_ref_reg <= 1'b0;
         alt_out_reg <= 1'b0;
         alt_oe_reg <= 1'b0;
      end else begin
         irq_pri_oe_reg <= irq_pri_oe_next;
         half_ref_reg <= half_ref_next;
         alt_out_reg <= alt_out_next;
         alt_oe_reg <= alt_oe_next;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign o_data_out = data_out_reg;
   assign o_data_oe = data_oe_reg;
   assign o_transfer_ack_out = ack_out_reg;
   assign o_transfer_ack_oe = ack_oe_reg;
   assign o_irq_primary_oe = irq_pri_oe_reg;
   assign o_half_supply_ref_en = half_ref_reg;
   assign o_alt_pin_out = alt_out_reg;
   assign o_alt_pin_oe = alt_oe_reg;
   assign o_miso_oe = miso_oe_reg;
   assign o_cpu_if_ctrl = ctrl_reg;

endmodule : can_host_pins

// ===== dv/can_host_pins_asserts.sv
// concurrent checks on the host pin interface ports
module can_host_pins_asserts (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_rw_n,
   input wire logic i_addr_ok_in,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_data,
   input wire logic i_ser_cs_n,
   input wire logic i_bus_type_hi,
   input wire logic i_bus_type_lo,
   input wire logic i_serial_mode,
   input wire logic i_irq_req,
   input wire logic i_port2_bit6_out,
   input wire logic i_port2_bit6_oe,
   input wire logic [7:0] o_data_out,
   input wire logic o_data_oe,
   input wire logic o_transfer_ack_out,
   input wire logic o_transfer_ack_oe,
   input wire logic o_irq_primary_oe,
   input wire logic o_half_supply_ref_en,
   input wire logic o_alt_pin_oe,
   input wire logic o_miso_oe,
   input wire logic [7:0] o_cpu_if_ctrl
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   wire logic par_mode = i_bus_type_hi && i_bus_type_lo && !i_serial_mode;
   wire logic sel = o_cpu_if_ctrl[can_host_pkg::INT_PIN_SELECT_BIT];
   wire logic [7:0] rd_exp = (i_addr == can_host_pkg::CPU_IF_CTRL_OFFSET) ? o_cpu_if_ctrl : can_host_pkg::READ_UNMAPPED;
   sequence s_ack_low;
      !o_transfer_ack_out && o_transfer_ack_oe;
   endsequence
   sequence s_start;
      par_mode && !i_cs_n && i_addr_ok_in && !$past(!i_cs_n && i_addr_ok_in);
   endsequence
   // two sync edges plus two state steps before the acknowledge
   property p_ack_time; s_start |-> ##1 o_transfer_ack_out [*3] ##1 s_ack_low; endproperty
   property p_read; s_ack_low ##0 i_rw_n |-> o_data_oe && o_data_out == rd_exp; endproperty
   property p_write;
      $fell(o_transfer_ack_out) && !i_rw_n && i_addr == can_host_pkg::CPU_IF_CTRL_OFFSET |-> o_cpu_if_ctrl == i_data;
   endproperty
   property p_release; s_ack_low ##0 $rose(i_cs_n || !i_addr_ok_in) |-> !o_transfer_ack_out [*3] ##1 o_transfer_ack_out; endproperty
   property p_pullup; $rose(o_transfer_ack_out) |-> o_transfer_ack_oe [*3] ##1 !o_transfer_ack_oe; endproperty
   property p_irq_pri; o_irq_primary_oe == ($past(i_irq_req) && !$past(sel)); endproperty
   // the first edge after reset still sees port inputs sampled inside reset
   property p_alt;
      !$past(i_rst) |-> o_alt_pin_oe == ($past(sel) ? $past(i_irq_req) : $past(i_port2_bit6_oe));
   endproperty
   property p_ref; o_half_supply_ref_en == $past(sel); endproperty
   property p_strap; !par_mode |-> !o_transfer_ack_oe && !o_data_oe; endproperty
   property p_miso; i_ser_cs_n [*5] |-> !o_miso_oe; endproperty
   a_ack_time: assert property (p_ack_time) else $error("ack not low four edges after start");
   a_read: assert property (p_read) else $error("read data wrong under ack");
   a_write: assert property (p_write) else $error("write not taken with ack");
   a_release: assert property (p_release) else $error("ack not released after cycle end");
   a_pullup: assert property (p_pullup) else $error("ack pull-up span wrong");
   a_irq_pri: assert property (p_irq_pri) else $error("primary interrupt pin wrong");
   a_alt: assert property (p_alt) else $error("alternate pin enable wrong");
   a_ref: assert property (p_ref) else $error("half-supply reference wrong");
   a_strap: assert property (p_strap) else $error("parallel bus active outside its mode");
   a_miso: assert property (p_miso) else $error("miso pulled while deselected");
endmodule : can_host_pins_asserts

bind can_host_pins can_host_pins_asserts chk (.i_clock(i_clock), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_rw_n(i_rw_n),
   .i_addr_ok_in(i_addr_ok_in), .i_addr(i_addr), .i_data(i_data), .i_ser_cs_n(i_ser_cs_n),
   .i_bus_type_hi(i_bus_type_hi), .i_bus_type_lo(i_bus_type_lo), .i_serial_mode(i_serial_mode),
   .i_irq_req(i_irq_req), .i_port2_bit6_out(i_port2_bit6_out), .i_port2_bit6_oe(i_port2_bit6_oe),
   .o_data_out(o_data_out), .o_data_oe(o_data_oe), .o_transfer_ack_out(o_transfer_ack_out),
   .o_transfer_ack_oe(o_transfer_ack_oe), .o_irq_primary_oe(o_irq_primary_oe),
   .o_half_supply_ref_en(o_half_supply_ref_en), .o_alt_pin_oe(o_alt_pin_oe), .o_miso_oe(o_miso_oe),
   .o_cpu_if_ctrl(o_cpu_if_ctrl));

// ===== dv/host_model.sv
// host cpu model driving the parallel and serial pins
module host_model (
   input wire logic i_clock,
   input wire logic i_ack_n,
   input wire logic [7:0] i_bus_data,
   input wire logic i_miso,
   output can_host_pkg::pin_in_t o_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   initial begin
      o_pins = '0;
      o_pins.cs_n = 1'b1;
      o_pins.rw_n = 1'b1;
      o_pins.ser_cs_n = 1'b1;
      o_pins.bus_type = 2'h3;
   end
   task setup(input logic ser, input logic idle, input logic ph);
      @(posedge i_clock);
      o_pins.serial_mode <= ser;
      o_pins.bus_type <= ser ? 2'h0 : 2'h3;
      o_pins.serial_clk_idle_level <= idle;
      o_pins.sclk <= idle;
      o_pins.sample_phase <= ph;
   endtask : setup
   task par(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      @(posedge i_clock);
      o_pins.cs_n <= 1'b0;
      o_pins.addr_ok_in <= 1'b1;
      o_pins.rw_n <= ~wr;
      o_pins.addr <= a;
      o_pins.data <= d;
      n = 0;
      do begin
         @(posedge i_clock);
         n++;
      end while (i_ack_n !== 1'b0 && n < 20);
      q = (i_ack_n === 1'b0) ? i_bus_data : 8'hxx;
      o_pins.cs_n <= 1'b1;
      o_pins.addr_ok_in <= 1'b0;
      o_pins.data <= ~d; // a released bus must not keep its last value
      repeat (8) @(posedge i_clock);
   endtask : par
   task ser(input logic [15:0] f, output logic [7:0] q);
      logic take;
      take = (o_pins.serial_clk_idle_level != o_pins.sample_phase);
      @(posedge i_clock);
      o_pins.ser_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         // mosi moves mid half-period, never on a clock edge
         repeat (2) @(posedge i_clock);
         o_pins.mosi <= f[i];
         for (int t = 0; t < 2; t++) begin
            repeat (4 + t) @(posedge i_clock);
            if (t == int'(take))
               q = {q[6:0], i_miso};
            o_pins.sclk <= ~o_pins.sclk;
         end
      end
      repeat (5) @(posedge i_clock);
      o_pins.ser_cs_n <= 1'b1;
      o_pins.mosi <= ~o_pins.mosi;
      repeat (10) @(posedge i_clock);
   endtask : ser
endmodule : host_model

// ===== dv/can_ctrl_host_interface_pins_bench.sv
// testbench for the host pin interface
module can_ctrl_host_interface_pins_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // pins and instances
   // ------------------------------------------------------------
   logic i_clock, i_rst, irq_req, p2_out, p2_oe;
   logic data_oe, ack_out, ack_oe, pri_oe, ref_en, alt_out, alt_oe, miso_oe;
   logic [7:0] data_out, ctrl, q;
   int miscompares = 0;
   int tests_run = 0;
   can_host_pkg::pin_in_t pins;
   wire logic ack_n = ack_oe ? ack_out : 1'b1;
   wire logic [7:0] bus = data_oe ? data_out : pins.data;
   wire logic miso = ~miso_oe;
   host_model host (.i_clock(i_clock), .i_ack_n(ack_n), .i_bus_data(bus), .i_miso(miso), .o_pins(pins));
   can_host_pins uut (
      .i_clock(i_clock), .i_rst(i_rst), .i_cs_n(pins.cs_n), .i_rw_n(pins.rw_n), .i_addr_ok_in(pins.addr_ok_in),
      .i_addr(pins.addr), .i_data(bus), .i_sclk(pins.sclk), .i_ser_cs_n(pins.ser_cs_n), .i_mosi(pins.mosi),
      .i_sample_phase(pins.sample_phase), .i_serial_clk_idle_level(pins.serial_clk_idle_level),
      .i_bus_type_hi(pins.bus_type[1]), .i_bus_type_lo(pins.bus_type[0]), .i_serial_mode(pins.serial_mode),
      .i_irq_req(irq_req), .i_port2_bit6_out(p2_out), .i_port2_bit6_oe(p2_oe), .o_data_out(data_out),
      .o_data_oe(data_oe), .o_transfer_ack_out(ack_out), .o_transfer_ack_oe(ack_oe), .o_irq_primary_oe(pri_oe),
      .o_half_supply_ref_en(ref_en), .o_alt_pin_out(alt_out), .o_alt_pin_oe(alt_oe), .o_miso_oe(miso_oe),
      .o_cpu_if_ctrl(ctrl));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task conclude;
      $display("miscompares %0d tests_run %0d", miscompares, tests_run);
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude
   // straps settle before release, first access well after the capture edges
   task do_reset(input logic ser, input logic idle, input logic ph);
      host.setup(ser, idle, ph);
      i_rst <= 1'b1;
      repeat (6) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (8) @(posedge i_clock);
   endtask : do_reset
   task sc_regs;
      host.par(1'b0, 8'h02, 8'h00, q);
      check("reset read", q, can_host_pkg::CPU_IF_CTRL_RESET);
      host.par(1'b1, 8'h02, 8'ha5, q);
      check("ctrl after write", ctrl, 8'ha5);
      host.par(1'b1, 8'h03, 8'hff, q);
      host.par(1'b0, 8'h03, 8'h00, q);
      check("unmapped read", q, can_host_pkg::READ_UNMAPPED);
      host.par(1'b0, 8'h02, 8'h00, q);
      check("back to back read", q, 8'ha5);
   endtask : sc_regs
   task sc_irq;
      host.par(1'b1, 8'h02, 8'h00, q);
      @(posedge i_clock);
      irq_req <= 1'b1;
      p2_out <= 1'b1;
      p2_oe <= 1'b1;
      repeat (3) @(posedge i_clock);
      check("irq primary", {4'h0, ref_en, pri_oe, alt_out, alt_oe}, 8'h07);
      host.par(1'b1, 8'h02, 8'h20, q);
      check("irq alternate", {4'h0, ref_en, pri_oe, alt_out, alt_oe}, 8'h09);
      irq_req <= 1'b0;
      repeat (3) @(posedge i_clock);
      check("irq idle", {4'h0, ref_en, pri_oe, alt_out, alt_oe}, 8'h08);
   endtask : sc_irq
   task sc_serial;
      logic [7:0] v;
      for (int k = 0; k < 4; k++) begin
         v = 8'h5a ^ 8'(k);
         do_reset(1'b1, k[1], k[0]);
         host.ser({1'b1, 7'h02, v}, q);
         check("serial write", ctrl, v);
         host.ser({1'b0, 7'h02, 8'h00}, q);
         check("serial read", q, v);
      end
   endtask : sc_serial
   // ------------------------------------------------------------
   // run
   // ------------------------------------------------------------
   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end
   initial begin
      #50000;
      miscompares++;
      conclude();
   end
   initial begin
      i_rst = 1'b1;
      irq_req = 1'b0;
      p2_out = 1'b0;
      p2_oe = 1'b0;
      do_reset(1'b0, 1'b0, 1'b0);
      sc_regs();
      sc_irq();
      sc_serial();
      conclude();
   end
endmodule : can_ctrl_host_interface_pins_bench
